//--- hdl/byte_nv_store_access.sv
// nonvolatile byte store with stall, armed programming sequence and ready interrupt
// Behaviour
// - 4K separate byte-addressable store, byte read/write
// - read stalls core four cycles
// - write start stalls core two cycles
// - erase 8.5 ms, write 4.5 ms timed
// - self-timed programming with busy indication
// - programming only via armed protective sequence
// - software waits busy clear before programming
// - erase-only: data ones, arm, strobe
// - write-only: arm with mode 2, strobe
// - software blocks interrupts during sequence
// - mode field selects erase/write action
// - strobe accepted within four cycles after arm
// - mode writes ignored while strobe set
// - ready interrupt while strobe clear, enabled
//
// Decided for this implementation: the APB register port and the placing of the registers.
module byte_nv_store_access #(
    parameter int WRITE_CYCLES = nv_store_pkg::WRITE_CYCLES,
    parameter int ERASE_CYCLES = nv_store_pkg::ERASE_CYCLES
) (
    input  wire logic clk_i,
    input  wire logic resetn_i,
    nv_link_if.store  link,
    output logic      busy_o
);
    // wide enough for the longest combined erase and write at the default rate
    localparam int CNT_W = 24;

    typedef struct packed {
        logic [11:0]      addr;
        logic [7:0]       data;
        logic [1:0]       sel;
        logic             rie;
        logic             arm;
        logic [2:0]       arm_cnt;
        logic             strobe;
        logic [CNT_W-1:0] prog_cnt;
        logic [2:0]       stall_cnt;
        logic             rd_pend;
        logic [1:0]       act;
        logic             erase_phase;
    } state_t;

    state_t st_reg, st_next;

    // =====================================================
    // storage array, separate from every other space
    // contents are not reset: cells keep their charge across a reset
    logic [7:0] mem [nv_store_pkg::STORE_BYTES];
    logic       mem_we;
    logic [7:0] mem_wval;
    logic [7:0] mem_cur;
    logic [7:0] prog_bits;

    always_ff @(posedge clk_i) begin
        if (mem_we) begin
            mem[st_reg.addr] <= mem_wval;
        end
    end

    assign mem_cur = mem[st_reg.addr];

    // a write can only pull cells low, as an unerased cell would
    for (genvar b = 0; b < nv_store_pkg::DATA_W; b++) begin : g_prog_bit
        assign prog_bits[b] = mem_cur[b] & st_reg.data[b];
    end

    // =====================================================
    // link decode
    logic       stall_busy;
    logic       prog_done;
    logic       arm_last;
    logic       take_wr;
    logic       ctl_read;
    logic       ctl_strobe;
    logic       ctl_arm;
    logic       ctl_rie;
    logic [1:0] ctl_sel;

    assign stall_busy = (st_reg.stall_cnt != 3'h0);
    assign prog_done  = (st_reg.prog_cnt == '0);
    assign arm_last   = (st_reg.arm_cnt == 3'(nv_store_pkg::ARM_WINDOW - 1));
    // writes landing inside a stall are dropped, as the core is halted then
    assign take_wr    = link.wr_en && !stall_busy;
    assign ctl_read   = link.wdata[nv_store_pkg::CTRL_READ_BIT];
    assign ctl_strobe = link.wdata[nv_store_pkg::CTRL_STROBE_BIT];
    assign ctl_arm    = link.wdata[nv_store_pkg::CTRL_ARM_BIT];
    assign ctl_rie    = link.wdata[nv_store_pkg::CTRL_RIE_BIT];
    assign ctl_sel    = link.wdata[nv_store_pkg::CTRL_SEL_LSB +: 2];

    // =====================================================
    // next state
    always_comb begin
        logic fire;
        fire     = 1'b0;
        st_next  = st_reg;
        mem_we   = 1'b0;
        mem_wval = st_reg.data;

        if (stall_busy) begin
            st_next.stall_cnt = st_reg.stall_cnt - 3'h1;
        end
        if (st_reg.rd_pend) begin
            st_next.data    = mem_cur;
            st_next.rd_pend = 1'b0;
        end

        // arm expires by itself after its window
        if (st_reg.arm) begin
            if (arm_last) begin
                st_next.arm = 1'b0;
            end else begin
                st_next.arm_cnt = st_reg.arm_cnt + 3'h1;
            end
        end

        // data and action freeze while an operation runs, so the cell gets what was armed
        if (take_wr) begin
            case (link.reg_sel)
                nv_store_pkg::REG_ADDR_LO: st_next.addr[7:0] = link.wdata;
                nv_store_pkg::REG_ADDR_HI: st_next.addr[11:8] = link.wdata[3:0];
                nv_store_pkg::REG_DATA:    if (!st_reg.strobe) st_next.data = link.wdata;
                nv_store_pkg::REG_CTRL: begin
                    st_next.rie = ctl_rie;
                    if (!st_reg.strobe) begin
                        st_next.sel = ctl_sel;
                    end
                    if (ctl_arm && !st_reg.arm) begin
                        st_next.arm     = 1'b1;
                        st_next.arm_cnt = 3'h0;
                    end
                    // strobe without live arm, while busy, or with the reserved action does nothing
                    if (ctl_strobe && st_reg.arm && !st_reg.strobe
                        && st_reg.sel != nv_store_pkg::ACT_RESERVED) begin
                        fire = 1'b1;
                    end
                    if (ctl_read && !st_reg.strobe) begin
                        st_next.rd_pend   = 1'b1;
                        st_next.stall_cnt = 3'(nv_store_pkg::READ_STALL);
                    end
                end
                default: ;
            endcase
        end

        // mode 0 runs the erase first and reloads the timer for the write
        if (fire) begin
            st_next.strobe      = 1'b1;
            st_next.arm         = 1'b0;
            st_next.act         = st_reg.sel;
            st_next.erase_phase = (st_reg.sel != nv_store_pkg::ACT_WRITE_ONLY);
            st_next.prog_cnt    = (st_reg.sel == nv_store_pkg::ACT_WRITE_ONLY)
                                ? CNT_W'(WRITE_CYCLES - 1) : CNT_W'(ERASE_CYCLES - 1);
            st_next.stall_cnt   = 3'(nv_store_pkg::WRITE_STALL);
        end else if (st_reg.strobe) begin
            if (!prog_done) begin
                st_next.prog_cnt = st_reg.prog_cnt - CNT_W'(1);
            end else if (st_reg.erase_phase) begin
                // erase leaves every bit high
                mem_we   = 1'b1;
                mem_wval = nv_store_pkg::ERASED_BYTE;
                if (st_reg.act == nv_store_pkg::ACT_ERASE_WRITE) begin
                    st_next.erase_phase = 1'b0;
                    st_next.prog_cnt    = CNT_W'(WRITE_CYCLES - 1);
                end else begin
                    st_next.strobe = 1'b0;
                end
            end else begin
                mem_we         = 1'b1;
                mem_wval       = prog_bits;
                st_next.strobe = 1'b0;
            end
        end
    end

    // a reset in mid-operation drops it; the cell is left as far as it got
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    // =====================================================
    // outputs
    logic [7:0] ctrl_view;

    // reserved bits read as zero; bit 0 is a pulse and never reads back
    assign ctrl_view = {2'b00, st_reg.sel, st_reg.rie, st_reg.arm, st_reg.strobe, 1'b0};

    always_comb begin
        case (link.reg_sel)
            nv_store_pkg::REG_ADDR_LO: link.rdata = st_reg.addr[7:0];
            nv_store_pkg::REG_ADDR_HI: link.rdata = {4'h0, st_reg.addr[11:8]};
            nv_store_pkg::REG_DATA:    link.rdata = st_reg.data;
            default:                   link.rdata = ctrl_view;
        endcase
    end

    assign link.stall     = stall_busy;
    // the ready request is a level, not a pulse: it stands while idle and enabled
    assign link.ready_irq = st_reg.rie && link.global_ie && !st_reg.strobe;
    assign busy_o         = st_reg.strobe;
endmodule

//--- hdl/nv_core_ctrl.sv
// APB-controlled core-side sequencer that drives the store link
module nv_core_ctrl (
    input  wire logic        clk_i,
    input  wire logic        resetn_i,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        global_ie_i,
    nv_link_if.core          link
);
    typedef enum logic [2:0] {
        S_IDLE  = 3'b000,
        S_WAIT  = 3'b001,
        S_ADDRL = 3'b010,
        S_ADDRH = 3'b011,
        S_DATA  = 3'b100,
        S_ARM   = 3'b101,
        S_FIRE  = 3'b110,
        S_DONE  = 3'b111
    } step_t;

    typedef struct packed {
        step_t      step;
        logic [2:0] cmd;
        logic [11:0] addr;
        logic [7:0] wdata;
        logic [7:0] rdata;
        logic [1:0] sel;
        logic       rie;
        logic       err;
    } state_t;

    state_t st_reg, st_next;
    logic   acc;
    logic   busy_seen;

    assign acc       = psel && penable;
    // the store control register shows the strobe in bit 1
    assign busy_seen = link.rdata[nv_store_pkg::CTRL_STROBE_BIT] || link.flash_busy;

    // =====================================================
    // sequencer
    always_comb begin
        st_next       = st_reg;
        link.wr_en    = 1'b0;
        link.rd_en    = 1'b0;
        link.reg_sel  = nv_store_pkg::REG_CTRL;
        link.wdata    = 8'h00;
        case (st_reg.step)
            S_IDLE: begin
                if (acc && pwrite && paddr == nv_store_pkg::APB_CMD && pwdata[2:0] != 3'h0) begin
                    st_next.cmd  = pwdata[2:0];
                    st_next.err  = 1'b0;
                    st_next.step = S_WAIT;
                end
                if (acc && pwrite && paddr == nv_store_pkg::APB_ADDR)  st_next.addr  = pwdata[11:0];
                if (acc && pwrite && paddr == nv_store_pkg::APB_WDATA) st_next.wdata = pwdata[7:0];
            end
            S_WAIT: begin
                // poll until neither the store nor flash is programming
                link.rd_en = 1'b1;
                if (!busy_seen && !link.stall) begin
                    case (st_reg.cmd)
                        nv_store_pkg::CMD_SET_RIE: st_next.rie = st_reg.wdata[0];
                        nv_store_pkg::CMD_ERASE_WRITE: st_next.sel = nv_store_pkg::ACT_ERASE_WRITE;
                        nv_store_pkg::CMD_ERASE:       st_next.sel = nv_store_pkg::ACT_ERASE_ONLY;
                        nv_store_pkg::CMD_WRITE:       st_next.sel = nv_store_pkg::ACT_WRITE_ONLY;
                        default: ;
                    endcase
                    st_next.step = (st_reg.cmd == nv_store_pkg::CMD_SET_RIE) ? S_ARM : S_ADDRL;
                end
            end
            S_ADDRL: begin
                link.wr_en   = 1'b1;
                link.reg_sel = nv_store_pkg::REG_ADDR_LO;
                link.wdata   = st_reg.addr[7:0];
                st_next.step = S_ADDRH;
            end
            S_ADDRH: begin
                link.wr_en   = 1'b1;
                link.reg_sel = nv_store_pkg::REG_ADDR_HI;
                link.wdata   = {4'h0, st_reg.addr[11:8]};
                st_next.step = S_DATA;
            end
            S_DATA: begin
                link.wr_en   = (st_reg.cmd != nv_store_pkg::CMD_READ);
                link.reg_sel = nv_store_pkg::REG_DATA;
                link.wdata   = (st_reg.cmd == nv_store_pkg::CMD_ERASE) ? nv_store_pkg::ERASED_BYTE
                                                                      : st_reg.wdata;
                st_next.step = S_ARM;
            end
            S_ARM: begin
                // arm write and strobe write go back to back, never split
                link.wr_en   = 1'b1;
                link.wdata   = {2'b00, st_reg.sel, st_reg.rie, 1'b0, 1'b0, 1'b0};
                if (st_reg.cmd == nv_store_pkg::CMD_READ) begin
                    link.wdata[nv_store_pkg::CTRL_READ_BIT] = 1'b1;
                    st_next.step = S_DONE;
                end else if (st_reg.cmd == nv_store_pkg::CMD_SET_RIE) begin
                    st_next.step = S_IDLE;
                end else begin
                    link.wdata[nv_store_pkg::CTRL_ARM_BIT] = 1'b1;
                    st_next.step = S_FIRE;
                end
            end
            S_FIRE: begin
                link.wr_en   = 1'b1;
                link.wdata   = {2'b00, st_reg.sel, st_reg.rie, 1'b1, 1'b1, 1'b0};
                st_next.step = S_DONE;
            end
            S_DONE: begin
                link.reg_sel = nv_store_pkg::REG_DATA;
                if (!link.stall) begin
                    if (st_reg.cmd == nv_store_pkg::CMD_READ) st_next.rdata = link.rdata;
                    st_next.step = S_IDLE;
                end
            end
            default: st_next.step = S_IDLE;
        endcase
        if (acc && pwrite && paddr == nv_store_pkg::APB_CMD && st_reg.step != S_IDLE) begin
            st_next.err = 1'b1;
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    // =====================================================
    // APB answers in the access cycle; sequence runs uninterrupted by the core
    assign link.global_ie = global_ie_i && (st_reg.step == S_IDLE);
    assign pready  = 1'b1;
    assign pslverr = 1'b0;
    always_comb begin
        case (paddr)
            nv_store_pkg::APB_CMD:    prdata = {29'h0, st_reg.cmd};
            nv_store_pkg::APB_ADDR:   prdata = {20'h0, st_reg.addr};
            nv_store_pkg::APB_WDATA:  prdata = {24'h0, st_reg.wdata};
            nv_store_pkg::APB_STATUS: prdata = {28'h0, link.ready_irq, st_reg.err, st_reg.rie,
                                                st_reg.step != S_IDLE};
            nv_store_pkg::APB_RDATA:  prdata = {24'h0, st_reg.rdata};
            default:                  prdata = 32'h0000_0000;
        endcase
    end
endmodule

//--- hdl/nv_link_if.sv
// register link between the core side and the nonvolatile store
interface nv_link_if;
    logic       wr_en;
    logic       rd_en;
    logic [1:0] reg_sel;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic       stall;
    logic       global_ie;
    logic       ready_irq;
    logic       flash_busy;

    modport store (
        input  wr_en, rd_en, reg_sel, wdata, global_ie,
        output rdata, stall, ready_irq
    );
    modport core (
        output wr_en, rd_en, reg_sel, wdata, global_ie,
        input  rdata, stall, ready_irq, flash_busy
    );
endinterface

//--- hdl/nv_store_pkg.sv
// shared constants and types for the byte nonvolatile store access logic
package nv_store_pkg;
    // =====================================================
    // store geometry
    localparam int ADDR_W    = 12;
    localparam int DATA_W    = 8;
    localparam int STORE_BYTES = 4096;

    // =====================================================
    // register indices on the core side of the link
    localparam logic [1:0] REG_ADDR_LO = 2'h0;
    localparam logic [1:0] REG_ADDR_HI = 2'h1;
    localparam logic [1:0] REG_DATA    = 2'h2;
    localparam logic [1:0] REG_CTRL    = 2'h3;

    // =====================================================
    // control register field positions
    localparam int CTRL_READ_BIT   = 0;
    localparam int CTRL_STROBE_BIT = 1;
    localparam int CTRL_ARM_BIT    = 2;
    localparam int CTRL_RIE_BIT    = 3;
    localparam int CTRL_SEL_LSB    = 4;

    // =====================================================
    // programming actions
    typedef enum logic [1:0] {
        ACT_ERASE_WRITE = 2'b00,
        ACT_ERASE_ONLY  = 2'b01,
        ACT_WRITE_ONLY  = 2'b10,
        ACT_RESERVED    = 2'b11
    } action_t;

    localparam logic [7:0] ERASED_BYTE = 8'hff;

    // =====================================================
    // timing
    localparam int CLK_HZ         = 200_000_000;
    localparam int READ_STALL     = 4;
    localparam int WRITE_STALL    = 2;
    localparam int ARM_WINDOW     = 4;
    localparam int WRITE_TIME_US  = 4500;
    localparam int ERASE_TIME_US  = 8500;
    localparam int WRITE_CYCLES   = WRITE_TIME_US * (CLK_HZ / 1_000_000);
    localparam int ERASE_CYCLES   = ERASE_TIME_US * (CLK_HZ / 1_000_000);

    // =====================================================
    // APB register offsets on the host controller
    localparam logic [7:0] APB_CMD    = 8'h00;
    localparam logic [7:0] APB_ADDR   = 8'h04;
    localparam logic [7:0] APB_WDATA  = 8'h08;
    localparam logic [7:0] APB_STATUS = 8'h0c;
    localparam logic [7:0] APB_RDATA  = 8'h10;

    // host command codes
    localparam logic [2:0] CMD_READ        = 3'h1;
    localparam logic [2:0] CMD_ERASE_WRITE = 3'h2;
    localparam logic [2:0] CMD_ERASE       = 3'h3;
    localparam logic [2:0] CMD_WRITE       = 3'h4;
    localparam logic [2:0] CMD_SET_RIE     = 3'h5;
endpackage

//--- test/byte_nv_store_access_bench.sv
// self-checking bench: apb-driven core sequencer joined to the store
module byte_nv_store_access_bench;
    timeunit 1ns;
    timeprecision 100ps;
    `define CHK(nm, exp, got) begin checks++; if ((got) !== (exp)) begin error_cnt++; \
        $display("unexpected %s expected %h seen %h", nm, exp, got); end end

    // =====================================================
    // clock, reset, design
    localparam int WR_CYC = 20;
    localparam int ER_CYC = 30;
    logic        clk_i = 1'b0;
    logic        resetn_i = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic        pready;
    logic        global_ie_i = 1'b0;
    logic        busy_o;
    int          error_cnt = 0;
    int          checks = 0;
    logic [31:0] q;
    nv_link_if nv_link_if_i ();
    initial nv_link_if_i.flash_busy = 1'b0;
    initial begin
        forever #2.5 clk_i = ~clk_i;
    end
    nv_core_ctrl nv_core_ctrl_i (
        .clk_i(clk_i), .resetn_i(resetn_i), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(),
        .global_ie_i(global_ie_i), .link(nv_link_if_i.core));
    byte_nv_store_access #(.WRITE_CYCLES(WR_CYC), .ERASE_CYCLES(ER_CYC)) byte_nv_store_access_i (
        .clk_i(clk_i), .resetn_i(resetn_i), .link(nv_link_if_i.store), .busy_o(busy_o));
    nv_link_sva #(.WRITE_CYCLES(WR_CYC), .ERASE_CYCLES(ER_CYC)) nv_link_sva_i (
        .clk_i(clk_i), .resetn_i(resetn_i), .wr_en(nv_link_if_i.wr_en), .reg_sel(nv_link_if_i.reg_sel),
        .wdata(nv_link_if_i.wdata), .rdata(nv_link_if_i.rdata), .stall(nv_link_if_i.stall),
        .global_ie(nv_link_if_i.global_ie), .ready_irq(nv_link_if_i.ready_irq), .busy_o(busy_o));

    // =====================================================
    // apb and command tasks
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
        int n;
        @(posedge clk_i);
        psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
        @(posedge clk_i);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (pready !== 1'b1 && n < 100);
        r = prdata;
        if (n >= 100) `CHK("apb ready", 1'b1, pready)
        psel <= 1'b0; penable <= 1'b0;
    endtask
    task automatic start_op(input logic [2:0] cmd, input logic [11:0] a, input logic [7:0] d);
        logic [31:0] r;
        apb(1'b1, nv_store_pkg::APB_ADDR, {20'h0_0000, a}, r);
        apb(1'b1, nv_store_pkg::APB_WDATA, {24'h00_0000, d}, r);
        apb(1'b1, nv_store_pkg::APB_CMD, {29'h0000_0000, cmd}, r);
    endtask
    task automatic wait_idle;
        logic [31:0] r;
        int n;
        n = 0;
        do begin
            apb(1'b0, nv_store_pkg::APB_STATUS, 32'h0000_0000, r);
            n++;
        end while (r[0] !== 1'b0 && n < 500);
        if (n >= 500) `CHK("status idle", 1'b0, r[0])
    endtask
    task automatic do_op(input logic [2:0] cmd, input logic [11:0] a, input logic [7:0] d);
        start_op(cmd, a, d);
        wait_idle();
    endtask
    task automatic rd_byte(input logic [11:0] a, output logic [7:0] b);
        logic [31:0] r;
        do_op(nv_store_pkg::CMD_READ, a, 8'h00);
        apb(1'b0, nv_store_pkg::APB_RDATA, 32'h0000_0000, r);
        b = r[7:0];
    endtask
    task automatic wait_busy(input logic lvl);
        int n;
        n = 0;
        while (busy_o !== lvl && n < 200) begin
            @(posedge clk_i);
            n++;
        end
        `CHK("store busy", lvl, busy_o)
    endtask
    task automatic tally_and_finish;
        $display("counts: %0d checks, %0d mismatches", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // =====================================================
    // tests
    initial begin
        // whole run needs under a thousand cycles
        repeat (50000) @(posedge clk_i);
        error_cnt++;
        tally_and_finish();
    end
    initial begin
        logic [7:0] b;
        repeat (16) @(posedge clk_i);
        resetn_i <= 1'b1;
        apb(1'b0, 8'h40, 32'h0000_0000, q);
        `CHK("unmapped read", 32'h0000_0000, q)
        `CHK("busy after reset", 1'b0, busy_o)
        $display("test reset done");
        do_op(nv_store_pkg::CMD_ERASE, 12'habc, 8'hff);
        rd_byte(12'habc, b);
        `CHK("erased byte", 8'hff, b)
        do_op(nv_store_pkg::CMD_WRITE, 12'habc, 8'h5a);
        rd_byte(12'habc, b);
        `CHK("write only", 8'h5a, b)
        do_op(nv_store_pkg::CMD_WRITE, 12'habc, 8'h0f);
        rd_byte(12'habc, b);
        `CHK("write only no erase", 8'h0a, b)
        do_op(nv_store_pkg::CMD_ERASE_WRITE, 12'habc, 8'hc3);
        rd_byte(12'habc, b);
        `CHK("erase and write", 8'hc3, b)
        $display("test actions done");
        do_op(nv_store_pkg::CMD_ERASE_WRITE, 12'hfff, 8'h11);
        do_op(nv_store_pkg::CMD_ERASE_WRITE, 12'h000, 8'h22);
        rd_byte(12'hfff, b);
        `CHK("top byte", 8'h11, b)
        rd_byte(12'h000, b);
        `CHK("bottom byte", 8'h22, b)
        $display("test address ends done");
        do_op(nv_store_pkg::CMD_ERASE, 12'h123, 8'hff);
        start_op(nv_store_pkg::CMD_WRITE, 12'h123, 8'h96);
        apb(1'b1, nv_store_pkg::APB_CMD, {29'h0000_0000, nv_store_pkg::CMD_ERASE}, q);
        apb(1'b0, nv_store_pkg::APB_STATUS, 32'h0000_0000, q);
        `CHK("refused command flag", 1'b1, q[2])
        wait_idle();
        rd_byte(12'h123, b);
        `CHK("refused command no effect", 8'h96, b)
        $display("test refusal done");
        do_op(nv_store_pkg::CMD_ERASE, 12'h456, 8'hff);
        nv_link_if_i.flash_busy <= 1'b1;
        start_op(nv_store_pkg::CMD_WRITE, 12'h456, 8'h3c);
        repeat (30) @(posedge clk_i);
        `CHK("held by flash busy", 1'b0, busy_o)
        nv_link_if_i.flash_busy <= 1'b0;
        wait_idle();
        rd_byte(12'h456, b);
        `CHK("write after flash busy", 8'h3c, b)
        $display("test flash wait done");
        do_op(nv_store_pkg::CMD_SET_RIE, 12'h000, 8'h01);
        global_ie_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        `CHK("ready irq idle", 1'b1, nv_link_if_i.ready_irq)
        start_op(nv_store_pkg::CMD_ERASE, 12'h789, 8'hff);
        wait_busy(1'b1);
        `CHK("ready irq busy", 1'b0, nv_link_if_i.ready_irq)
        wait_busy(1'b0);
        repeat (4) @(posedge clk_i);
        `CHK("ready irq after op", 1'b1, nv_link_if_i.ready_irq)
        global_ie_i <= 1'b0;
        @(posedge clk_i);
        @(negedge clk_i);
        `CHK("ready irq global off", 1'b0, nv_link_if_i.ready_irq)
        do_op(nv_store_pkg::CMD_SET_RIE, 12'h000, 8'h00);
        global_ie_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        `CHK("ready irq disabled", 1'b0, nv_link_if_i.ready_irq)
        $display("test ready interrupt done");
        tally_and_finish();
    end
endmodule

//--- test/nv_link_sva.sv
// concurrent checks on the store link between the core sequencer and the store
module nv_link_sva #(
    parameter int WRITE_CYCLES = 20,
    parameter int ERASE_CYCLES = 30
) (
    input wire logic       clk_i,
    input wire logic       resetn_i,
    input wire logic       wr_en,
    input wire logic [1:0] reg_sel,
    input wire logic [7:0] wdata,
    input wire logic [7:0] rdata,
    input wire logic       stall,
    input wire logic       global_ie,
    input wire logic       ready_irq,
    input wire logic       busy_o
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge clk_i); endclocking
    default disable iff (!resetn_i);

    // =====================================================
    // helper logic
    logic        ctrl_wr;
    logic        fire;
    logic        rd_go;
    logic [31:0] busy_cnt_reg;
    logic [1:0]  mode_reg;
    logic [31:0] prog_len;
    assign ctrl_wr = wr_en && reg_sel == nv_store_pkg::REG_CTRL && !stall;
    // readback of the control register shows the arm bit while the fire write is on the link
    assign fire  = ctrl_wr && wdata[1] && rdata[2] && !busy_o && wdata[5:4] != 2'h3;
    assign rd_go = ctrl_wr && wdata[0] && !busy_o;
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            busy_cnt_reg <= 32'h0000_0000;
            mode_reg     <= 2'h0;
        end else begin
            busy_cnt_reg <= busy_o ? busy_cnt_reg + 32'h0000_0001 : 32'h0000_0000;
            if (fire) begin
                mode_reg <= wdata[5:4];
            end
        end
    end
    always_comb begin
        case (mode_reg)
            2'h1:    prog_len = ERASE_CYCLES;
            2'h2:    prog_len = WRITE_CYCLES;
            default: prog_len = ERASE_CYCLES + WRITE_CYCLES;
        endcase
    end

    // =====================================================
    // assertions
    a_read_stall_four: assert property (rd_go |=> stall [*4] ##1 !stall)
        else $error("read stall length wrong");
    a_write_stall_two: assert property (fire |=> stall [*2] ##1 !stall)
        else $error("write stall length wrong");
    a_busy_on_fire: assert property (fire |=> busy_o)
        else $error("busy not set by armed strobe");
    a_prog_time_exact: assert property ($fell(busy_o) |-> busy_cnt_reg == prog_len)
        else $error("programming time does not match action");
    a_stall_has_cause: assert property ($rose(stall) |-> $past(ctrl_wr))
        else $error("stall without control write");
    a_busy_has_cause: assert property ($rose(busy_o) |-> $past(fire))
        else $error("programming started without armed sequence");
    a_mode_held_busy: assert property ((busy_o && reg_sel == nv_store_pkg::REG_CTRL)
        |-> rdata[5:4] == mode_reg)
        else $error("action field changed while programming");
    a_irq_off_busy: assert property (busy_o |-> !ready_irq)
        else $error("ready interrupt while programming");
    a_irq_on_idle: assert property ((reg_sel == nv_store_pkg::REG_CTRL && rdata[3] && global_ie
        && !busy_o) |-> ready_irq)
        else $error("ready interrupt missing while idle");
    a_irq_gated_ie: assert property (!global_ie |-> !ready_irq)
        else $error("ready interrupt without global enable");
endmodule
